// *** hw/sfcd_core.v ***
`timescale 1ns/1ns
`include "sfcd_regs.vh"
module sfcd_core #(
	parameter PENW_US   = `SFCD_PENW_US,
	parameter QPB_INIT  = 1'b0,
	parameter RSEL_INIT = 1'b0,
	parameter PENB_INIT = 1'b0
) (
	input  wire        clock,
	input  wire        rst_n,
	input  wire        sck,
	input  wire        cs_n,
	input  wire [3:0]  sio_i,
	output reg  [3:0]  sio_o,
	output reg  [3:0]  sio_oe,
	input  wire [7:0]  status_in,
	input  wire        wel_in,
	input  wire        lock_bits_set,
	input  wire [7:0]  array_data,
	output reg         array_next,
	output reg         cmd_start,
	output reg  [7:0]  cmd_opcode,
	output reg         cmd_foreign,
	output reg         addr_valid,
	output reg  [23:0] cmd_addr,
	output reg         mem_reset,
	output reg         quad_mode,
	output reg         quad_pin_config_bit,
	output reg         reset_pause_select,
	output reg         protect_pin_enable_bit,
	output reg         protect_volatility_flag,
	output reg         hw_write_protect,
	output reg         pause_active,
	output reg         pin_reset,
	output reg         nv_busy
);
	localparam [2:0]  ST_CMD   = 3'h0;
	localparam [2:0]  ST_ADDR  = 3'h1;
	localparam [2:0]  ST_DUMMY = 3'h2;
	localparam [2:0]  ST_DOUT  = 3'h3;
	localparam [2:0]  ST_DIN   = 3'h4;
	localparam [2:0]  ST_IGN   = 3'h5;
	localparam [31:0] WCYC_W   = PENW_US * `SFCD_CLK_MHZ;
	localparam [15:0] WCYC     = WCYC_W[15:0]; // Busy counter is 16 bits wide

	wire        cs_s;
	wire        sck_s;
	wire [3:0]  sio_s;
	reg         sck_q;
	reg  [2:0]  state_q;
	reg  [5:0]  cnt_q;
	reg  [23:0] sh_q;
	reg  [18:0] dec_q;
	reg  [2:0]  bit_q;
	reg  [7:0]  out_q;
	reg  [1:0]  nbyte_q;
	reg  [7:0]  cfgin_q;
	reg         arm_q;
	reg  [15:0] busy_q;
	reg  [7:0]  cfg_w;
	reg  [7:0]  src_w;

	// Pin synchronisers
	sfcd_sync #(
		.W    (6),
		.INIT (`SFCD_PIN_INIT)
	) u_sync (
		.clock (clock),
		.rst_n (rst_n),
		.d     ({cs_n, sck, sio_i}),
		.q     ({cs_s, sck_s, sio_s})
	);

	// Shift lane bits into a word
	function [23:0] fn_shin;
		input [23:0] s;
		input [1:0]  ln;
		input [3:0]  d;
		begin
			case (ln)
				`SFCD_LN2: fn_shin = {s[21:0], d[1:0]};
				`SFCD_LN4: fn_shin = {s[19:0], d};
				default:   fn_shin = {s[22:0], d[0]};
			endcase
		end
	endfunction

	// Top bits of a byte onto the output lanes
	function [3:0] fn_top;
		input [7:0] b;
		input [1:0] ln;
		begin
			case (ln)
				`SFCD_LN2: fn_top = {2'h0, b[7:6]};
				`SFCD_LN4: fn_top = b[7:4];
				default:   fn_top = {2'h0, b[7], 1'b0};
			endcase
		end
	endfunction

	// Lanes driven per width
	function [3:0] fn_oe;
		input [1:0] ln;
		begin
			case (ln)
				`SFCD_LN2: fn_oe = 4'h3;
				`SFCD_LN4: fn_oe = 4'hF;
				default:   fn_oe = 4'h2;
			endcase
		end
	endfunction

	// Bits moved per edge
	function [2:0] fn_step;
		input [1:0] ln;
		begin
			case (ln)
				`SFCD_LN2: fn_step = 3'h2;
				`SFCD_LN4: fn_step = 3'h4;
				default:   fn_step = 3'h1;
			endcase
		end
	endfunction

	// Data state after the setup phases
	function [2:0] fn_dst;
		input [2:0] k;
		begin
			case (k)
				`SFCD_K_WRSR: fn_dst = ST_DIN;
				`SFCD_K_NONE: fn_dst = ST_IGN;
				default:      fn_dst = ST_DOUT;
			endcase
		end
	endfunction

	// Opcode table: ok, address clocks, dummy clocks, lanes, double rate, kind
	function [18:0] fn_dec;
		input [7:0] op;
		input       q;
		input       io;
		reg   [18:0] r;
		begin
			r = 19'h0;
			if (q) begin
				// Four-wire mode ignores the quad pin bit
				case (op)
					`SFCD_OP_NOP, `SFCD_OP_ARM, `SFCD_OP_RST, `SFCD_OP_RSTQIO:
						r = {1'b1, `SFCD_Z, `SFCD_Z, `SFCD_LN4, `SFCD_LN4, 1'b0, `SFCD_K_NONE};
					`SFCD_OP_RDSR:
						r = {1'b1, `SFCD_Z, `SFCD_DC_X4, `SFCD_LN4, `SFCD_LN4, 1'b0, `SFCD_K_STAT};
					`SFCD_OP_RDCR:
						r = {1'b1, `SFCD_Z, `SFCD_DC_X4, `SFCD_LN4, `SFCD_LN4, 1'b0, `SFCD_K_CFG};
					`SFCD_OP_WRSR:
						r = {1'b1, `SFCD_Z, `SFCD_Z, `SFCD_LN4, `SFCD_LN4, 1'b0, `SFCD_K_WRSR};
					`SFCD_OP_FREAD, `SFCD_OP_WBSQ:
						r = {1'b1, `SFCD_AC_X4, `SFCD_DC_3X4, `SFCD_LN4, `SFCD_LN4, 1'b0, `SFCD_K_ARR};
					`SFCD_OP_FRDTR:
						r = {1'b1, `SFCD_AC_DTR_X4, `SFCD_DC_DTR, `SFCD_LN4, `SFCD_LN4, 1'b1, `SFCD_K_ARR};
					`SFCD_OP_QJID:
						r = {1'b1, `SFCD_Z, `SFCD_DC_X4, `SFCD_LN4, `SFCD_LN4, 1'b0, `SFCD_K_ARR};
					default: r = 19'h0;
				endcase
			end else begin
				case (op)
					`SFCD_OP_NOP, `SFCD_OP_ARM, `SFCD_OP_RST, `SFCD_OP_EQIO, `SFCD_OP_RSTQIO:
						r = {1'b1, `SFCD_Z, `SFCD_Z, `SFCD_LN1, `SFCD_LN1, 1'b0, `SFCD_K_NONE};
					`SFCD_OP_RDSR:
						r = {1'b1, `SFCD_Z, `SFCD_Z, `SFCD_LN1, `SFCD_LN1, 1'b0, `SFCD_K_STAT};
					`SFCD_OP_RDCR:
						r = {1'b1, `SFCD_Z, `SFCD_Z, `SFCD_LN1, `SFCD_LN1, 1'b0, `SFCD_K_CFG};
					`SFCD_OP_WRSR:
						r = {1'b1, `SFCD_Z, `SFCD_Z, `SFCD_LN1, `SFCD_LN1, 1'b0, `SFCD_K_WRSR};
					`SFCD_OP_READ:
						r = {1'b1, `SFCD_AC_X1, `SFCD_Z, `SFCD_LN1, `SFCD_LN1, 1'b0, `SFCD_K_ARR};
					`SFCD_OP_FREAD, `SFCD_OP_SFDP:
						r = {1'b1, `SFCD_AC_X1, `SFCD_DC_X1, `SFCD_LN1, `SFCD_LN1, 1'b0, `SFCD_K_ARR};
					`SFCD_OP_QOR:
						r = {1'b1, `SFCD_AC_X1, `SFCD_DC_X1, `SFCD_LN1, `SFCD_LN4, 1'b0, `SFCD_K_ARR};
					`SFCD_OP_QIOR, `SFCD_OP_WBSP:
						r = {1'b1, `SFCD_AC_X4, `SFCD_DC_3X4, `SFCD_LN4, `SFCD_LN4, 1'b0, `SFCD_K_ARR};
					`SFCD_OP_DOR:
						r = {1'b1, `SFCD_AC_X1, `SFCD_DC_X1, `SFCD_LN1, `SFCD_LN2, 1'b0, `SFCD_K_ARR};
					`SFCD_OP_DIOR:
						r = {1'b1, `SFCD_AC_X2, `SFCD_DC_X2, `SFCD_LN2, `SFCD_LN2, 1'b0, `SFCD_K_ARR};
					`SFCD_OP_FRDTR:
						r = {1'b1, `SFCD_AC_DTR_X1, `SFCD_DC_DTR, `SFCD_LN1, `SFCD_LN1, 1'b1, `SFCD_K_ARR};
					`SFCD_OP_QORDTR:
						r = {1'b1, `SFCD_AC_DTR_X1, `SFCD_DC_DTR, `SFCD_LN1, `SFCD_LN4, 1'b1, `SFCD_K_ARR};
					`SFCD_OP_QIORDTR:
						r = {1'b1, `SFCD_AC_DTR_X4, `SFCD_DC_DTR, `SFCD_LN4, `SFCD_LN4, 1'b1, `SFCD_K_ARR};
					`SFCD_OP_DORDTR:
						r = {1'b1, `SFCD_AC_DTR_X1, `SFCD_DC_DTR, `SFCD_LN1, `SFCD_LN2, 1'b1, `SFCD_K_ARR};
					`SFCD_OP_DIORDTR:
						r = {1'b1, `SFCD_AC_DTR_X2, `SFCD_DC_DTR, `SFCD_LN2, `SFCD_LN2, 1'b1, `SFCD_K_ARR};
					`SFCD_OP_JID:
						r = {1'b1, `SFCD_Z, `SFCD_Z, `SFCD_LN1, `SFCD_LN1, 1'b0, `SFCD_K_ARR};
					default: r = 19'h0;
				endcase
				// Quad commands need the quad pin bit
				case (op)
					`SFCD_OP_QOR, `SFCD_OP_QIOR, `SFCD_OP_WBSP,
					`SFCD_OP_QORDTR, `SFCD_OP_QIORDTR:
						r[`SFCD_F_OK] = r[`SFCD_F_OK] & io;
					default: r[`SFCD_F_OK] = r[`SFCD_F_OK];
				endcase
			end
			fn_dec = r;
		end
	endfunction

	// Edge detection and current lane choice
	wire        rise_w  = sck_s & ~sck_q;
	wire        fall_w  = ~sck_s & sck_q;
	wire [1:0]  cln_w   = quad_mode ? `SFCD_LN4 : `SFCD_LN1;
	wire [23:0] cin_w   = fn_shin(sh_q, cln_w, sio_s);
	wire [23:0] ain_w   = fn_shin(sh_q, dec_q[`SFCD_F_AL], sio_s);
	wire [18:0] dec_w   = fn_dec(cin_w[7:0], quad_mode, quad_pin_config_bit);
	wire [18:0] dsg_w   = fn_dec(cin_w[7:0], 1'b0, 1'b1);
	wire [18:0] dqd_w   = fn_dec(cin_w[7:0], 1'b1, 1'b1);
	wire        qpp_w   = cin_w[7:0] == `SFCD_OP_QPP;
	wire        local_w = dsg_w[`SFCD_F_OK] | dqd_w[`SFCD_F_OK] | qpp_w;
	wire        pdat_w  = quad_pin_config_bit | quad_mode;
	wire [5:0]  cnt_n   = cnt_q + 6'h01;
	wire [5:0]  cmdl_w  = quad_mode ? `SFCD_CMD_CLK_X4 : `SFCD_CMD_CLK_X1;
	wire        dtr_w   = dec_q[`SFCD_F_DTR];
	wire [5:0]  alim_w  = dtr_w ? {dec_q[`SFCD_F_AC], 1'b0} : {1'b0, dec_q[`SFCD_F_AC]};
	wire [2:0]  dstep_w = fn_step(dec_q[`SFCD_F_DL]);
	wire [2:0]  istep_w = fn_step(cln_w);
	wire [2:0]  ibit_n  = bit_q + istep_w;

	// Configuration read image
	always @* begin
		cfg_w = 8'h00;
		cfg_w[`SFCD_CFG_QPB]  = quad_pin_config_bit;
		cfg_w[`SFCD_CFG_VOLF] = protect_volatility_flag;
		cfg_w[`SFCD_CFG_RSEL] = reset_pause_select;
		cfg_w[`SFCD_CFG_PENB] = protect_pin_enable_bit;
	end

	// Source byte for output phase
	always @* begin
		case (dec_q[`SFCD_F_K])
			`SFCD_K_CFG:  src_w = cfg_w;
			`SFCD_K_STAT: src_w = status_in;
			default:      src_w = array_data;
		endcase
	end

	// Pin roles, protection and busy interval
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			hw_write_protect        <= 1'b0;
			pause_active            <= 1'b0;
			pin_reset               <= 1'b0;
			protect_volatility_flag <= 1'b1;
			nv_busy                 <= 1'b0;
		end else begin
			hw_write_protect        <= protect_pin_enable_bit & ~sio_s[2] & ~pdat_w;
			pause_active            <= ~pdat_w & ~reset_pause_select & ~sio_s[3];
			pin_reset               <= ~pdat_w & reset_pause_select & ~sio_s[3];
			protect_volatility_flag <= ~lock_bits_set;
			nv_busy                 <= busy_q != 16'h0000;
		end
	end

	// Serial decoder
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sck_q <= 1'b0; state_q <= ST_CMD; cnt_q <= 6'h00; sh_q <= 24'h000000;
			dec_q <= 19'h0; bit_q <= 3'h0; out_q <= 8'h00; nbyte_q <= 2'h0;
			cfgin_q <= 8'h00; arm_q <= 1'b0; busy_q <= 16'h0000;
			sio_o <= 4'h0; sio_oe <= 4'h0; array_next <= 1'b0; cmd_start <= 1'b0;
			cmd_opcode <= 8'h00; cmd_foreign <= 1'b0; addr_valid <= 1'b0;
			cmd_addr <= 24'h000000; mem_reset <= 1'b0; quad_mode <= 1'b0;
			quad_pin_config_bit    <= QPB_INIT;
			reset_pause_select     <= RSEL_INIT;
			protect_pin_enable_bit <= PENB_INIT;
		end else begin
			sck_q       <= sck_s;
			array_next  <= 1'b0;
			cmd_start   <= 1'b0;
			cmd_foreign <= 1'b0;
			addr_valid  <= 1'b0;
			mem_reset   <= 1'b0;
			if (busy_q != 16'h0000) begin
				busy_q <= busy_q - 16'h0001;
			end
			if (cs_s || pin_reset) begin
				// Deselect applies a completed configuration write
				if (state_q == ST_DIN && nbyte_q == `SFCD_WRSR_BYTES && wel_in
						&& !hw_write_protect) begin
					quad_pin_config_bit <= cfgin_q[`SFCD_CFG_QPB];
					reset_pause_select  <= cfgin_q[`SFCD_CFG_RSEL];
					protect_pin_enable_bit <= cfgin_q[`SFCD_CFG_PENB];
					if (cfgin_q[`SFCD_CFG_PENB] != protect_pin_enable_bit) begin
						busy_q <= WCYC;
					end
				end
				if (pin_reset) begin
					quad_mode <= 1'b0;
				end
				state_q <= ST_CMD;
				cnt_q   <= 6'h00;
				bit_q   <= 3'h0;
				nbyte_q <= 2'h0;
				sio_oe  <= 4'h0;
			end else begin
				case (state_q)
					ST_CMD: begin
						if (rise_w) begin
							sh_q  <= cin_w;
							cnt_q <= cnt_n;
							if (cnt_n == cmdl_w) begin
								cmd_start  <= 1'b1;
								cmd_opcode <= cin_w[7:0];
								dec_q      <= dec_w;
								cnt_q      <= 6'h00;
								bit_q      <= 3'h0;
								arm_q      <= cin_w[7:0] == `SFCD_OP_ARM;
								if (!local_w || (qpp_w && !quad_mode && quad_pin_config_bit)) begin
									cmd_foreign <= 1'b1;
									state_q     <= ST_IGN;
								end else if (!dec_w[`SFCD_F_OK]) begin
									state_q <= ST_IGN;
								end else begin
									case (cin_w[7:0])
										`SFCD_OP_RST: begin
											if (arm_q) begin
												mem_reset <= 1'b1;
												quad_mode <= 1'b0;
											end
										end
										`SFCD_OP_EQIO:   quad_mode <= 1'b1;
										`SFCD_OP_RSTQIO: quad_mode <= 1'b0;
										default:         quad_mode <= quad_mode;
									endcase
									if (dec_w[`SFCD_F_AC] != `SFCD_Z) begin
										state_q <= ST_ADDR;
									end else if (dec_w[`SFCD_F_DC] != `SFCD_Z) begin
										state_q <= ST_DUMMY;
									end else begin
										state_q <= fn_dst(dec_w[`SFCD_F_K]);
									end
								end
							end
						end
					end
					ST_ADDR: begin
						// Double rate takes both edges, starting on a rising one
						if (rise_w || (fall_w && dtr_w && cnt_q != 6'h00)) begin
							sh_q  <= ain_w;
							cnt_q <= cnt_n;
							if (cnt_n == alim_w) begin
								cmd_addr   <= ain_w;
								addr_valid <= 1'b1;
								cnt_q      <= 6'h00;
								if (dec_q[`SFCD_F_DC] != `SFCD_Z) begin
									state_q <= ST_DUMMY;
								end else begin
									state_q <= fn_dst(dec_q[`SFCD_F_K]);
								end
							end
						end
					end
					ST_DUMMY: begin
						if (rise_w) begin
							cnt_q <= cnt_n;
							if (cnt_n == {1'b0, dec_q[`SFCD_F_DC]}) begin
								cnt_q   <= 6'h00;
								state_q <= fn_dst(dec_q[`SFCD_F_K]);
							end
						end
					end
					ST_DOUT: begin
						// Drive after falling edges, also rising ones at double rate
						if (fall_w || (rise_w && dtr_w)) begin
							sio_oe <= fn_oe(dec_q[`SFCD_F_DL]);
							bit_q  <= bit_q + dstep_w;
							if (bit_q == 3'h0) begin
								sio_o      <= fn_top(src_w, dec_q[`SFCD_F_DL]);
								out_q      <= src_w << dstep_w;
								array_next <= dec_q[`SFCD_F_K] == `SFCD_K_ARR;
							end else begin
								sio_o <= fn_top(out_q, dec_q[`SFCD_F_DL]);
								out_q <= out_q << dstep_w;
							end
						end
					end
					ST_DIN: begin
						if (rise_w) begin
							sh_q  <= cin_w;
							bit_q <= ibit_n;
							if (ibit_n == 3'h0 && nbyte_q != `SFCD_WRSR_BYTES) begin
								nbyte_q <= nbyte_q + 2'h1;
								if (nbyte_q == 2'h1) begin
									cfgin_q <= cin_w[7:0];
								end
							end
						end
					end
					default: state_q <= ST_IGN;
				endcase
			end
		end
	end
endmodule

// *** common/sfcd_regs.vh ***
// Operation
// - Host writes one to configuration bit 1 to enable quad pins; device stores it.
// - Bit clear: protect and pause pins are controls; set: they are data lines.
// - In single-wire mode, quad commands need the quad pin bit; otherwise invalid.
// - In four-wire mode the quad pin bit affects neither pins nor commands.
// - Quad pin bit power-up value is a build parameter: zero or one by variant.
// - Volatility flag reads one until any permanent lock bit is set, then zero.
// - Non-volatile select bit makes the shared pin a reset or pause input.
// - Hardware protection only while protect pin low and enable bit one.
// - Changing the protect enable bit starts a self-timed busy interval.
// - Under hardware protection only protection and configuration writes are rejected.
// - Quad output read: single-wire only, three address and one dummy cycle.
// - Dual I/O read: single-wire only, three address and one dummy cycle.
// - Double-rate quad I/O read: single-wire only, three address, six dummy.
// - Double-rate dual I/O read: single-wire only, six address, six dummy.
// - Command byte takes eight clocks single-wire, two clocks four-wire.
// - Address and data take eight clocks a byte on one lane, four on two, two on four, half at double rate; dummy clocks per command.
// - Memory reset runs only straight after the reset arm command.
`ifndef SFCD_REGS_VH
`define SFCD_REGS_VH

// Configuration register fields
`define SFCD_CFG_QPB      1
`define SFCD_CFG_VOLF     3
`define SFCD_CFG_RSEL     6
`define SFCD_CFG_PENB     7

// Timing
`define SFCD_CLK_MHZ      10
`define SFCD_PENW_US      10
`define SFCD_CMD_CLK_X1   6'h08
`define SFCD_CMD_CLK_X4   6'h02
`define SFCD_WRSR_BYTES   2'h2
`define SFCD_PIN_INIT     6'h2F

// Opcodes
`define SFCD_OP_NOP       8'h00
`define SFCD_OP_ARM       8'h66
`define SFCD_OP_RST       8'h99
`define SFCD_OP_EQIO      8'h38
`define SFCD_OP_RSTQIO    8'hFF
`define SFCD_OP_RDSR      8'h05
`define SFCD_OP_WRSR      8'h01
`define SFCD_OP_RDCR      8'h35
`define SFCD_OP_READ      8'h03
`define SFCD_OP_FREAD     8'h0B
`define SFCD_OP_QOR       8'h6B
`define SFCD_OP_QIOR      8'hEB
`define SFCD_OP_DOR       8'h3B
`define SFCD_OP_DIOR      8'hBB
`define SFCD_OP_WBSQ      8'h0C
`define SFCD_OP_WBSP      8'hEC
`define SFCD_OP_FRDTR     8'h0D
`define SFCD_OP_QORDTR    8'h6D
`define SFCD_OP_QIORDTR   8'hED
`define SFCD_OP_DORDTR    8'h3D
`define SFCD_OP_DIORDTR   8'hBD
`define SFCD_OP_JID       8'h9F
`define SFCD_OP_QJID      8'hAF
`define SFCD_OP_SFDP      8'h5A
`define SFCD_OP_QPP       8'h32

// Phase lengths in serial clocks
`define SFCD_Z            5'h00
`define SFCD_AC_X1        5'h18
`define SFCD_AC_X2        5'h0C
`define SFCD_AC_X4        5'h06
`define SFCD_DC_X1        5'h08
`define SFCD_DC_X2        5'h04
`define SFCD_DC_X4        5'h02
`define SFCD_DC_3X4       5'h06
`define SFCD_AC_DTR_X1    5'h0C
`define SFCD_AC_DTR_X2    5'h06
`define SFCD_AC_DTR_X4    5'h03
`define SFCD_DC_DTR       5'h06

// Lane codes and data kinds
`define SFCD_LN1          2'h0
`define SFCD_LN2          2'h1
`define SFCD_LN4          2'h2
`define SFCD_K_NONE       3'h0
`define SFCD_K_CFG        3'h1
`define SFCD_K_STAT       3'h2
`define SFCD_K_ARR        3'h3
`define SFCD_K_WRSR       3'h4

// Decode word fields
`define SFCD_F_OK         18
`define SFCD_F_AC         17:13
`define SFCD_F_DC         12:8
`define SFCD_F_AL         7:6
`define SFCD_F_DL         5:4
`define SFCD_F_DTR        3
`define SFCD_F_K          2:0

`endif

// *** hw/sfcd_sync.v ***
`timescale 1ns/1ns
// Two-flop synchroniser for pins
module sfcd_sync #(
	parameter         W    = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	input  wire         clock,
	input  wire         rst_n,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] meta_q;

	// First stage feeds only the second
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= INIT;
			q      <= INIT;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// *** test/sfcd_core_props.sv ***
`timescale 1ns/1ns
// Checker for decoder pulses, config bits and pin roles
module sfcd_core_props #(
	parameter PENW_US = 10
) (
	input wire       clock,
	input wire       rst_n,
	input wire       cs_n,
	input wire [3:0] sio_oe,
	input wire       wel_in,
	input wire       lock_bits_set,
	input wire       cmd_start,
	input wire [7:0] cmd_opcode,
	input wire       addr_valid,
	input wire       mem_reset,
	input wire       quad_mode,
	input wire       quad_pin_config_bit,
	input wire       reset_pause_select,
	input wire       protect_pin_enable_bit,
	input wire       protect_volatility_flag,
	input wire       hw_write_protect,
	input wire       pause_active,
	input wire       pin_reset,
	input wire       nv_busy
);
	localparam int BUSY_MAX = PENW_US * 10;
	reg [7:0]  op_q;
	reg        refused_q;
	reg [15:0] busy_cnt_q;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Previous opcode, refused quad frame, busy length
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			op_q <= 8'h00;
			refused_q <= 1'b0;
			busy_cnt_q <= 16'h0000;
		end else begin
			if (cmd_start)
				op_q <= cmd_opcode;
			if (cmd_start && !quad_mode && !quad_pin_config_bit
				&& (cmd_opcode == 8'h6B || cmd_opcode == 8'hEB))
				refused_q <= 1'b1;
			else if (cs_n)
				refused_q <= 1'b0;
			busy_cnt_q <= nv_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
		end
	end
	a_oe_idle_cs: assert property (cs_n [*4] |-> sio_oe == 4'h0)
		else $error("outputs driven while deselected");
	a_quad_refused: assert property (refused_q |-> !addr_valid)
		else $error("quad read accepted without quad pins");
	a_lanes_two_three: assert property (!quad_mode && !quad_pin_config_bit |-> sio_oe[3:2] == 2'h0)
		else $error("control pins driven");
	a_hwp_cause: assert property (hw_write_protect |-> protect_pin_enable_bit && !quad_pin_config_bit)
		else $error("write protect without enable");
	a_lock_flag: assert property (lock_bits_set |=> !protect_volatility_flag)
		else $error("volatility flag ignores lock");
	a_reset_pair: assert property (cmd_start && cmd_opcode == 8'h99 && op_q == 8'h66 |-> ##[0:20] mem_reset)
		else $error("armed reset not executed");
	a_reset_cause: assert property (mem_reset |-> cmd_opcode == 8'h99)
		else $error("reset from wrong opcode");
	a_busy_start: assert property ($changed(protect_pin_enable_bit) |-> ##[0:1] nv_busy)
		else $error("no busy after enable change");
	a_busy_min: assert property ($rose(nv_busy) |-> nv_busy [*8])
		else $error("busy too short");
	a_busy_max: assert property (nv_busy |-> busy_cnt_q <= BUSY_MAX)
		else $error("busy too long");
	a_pause_role: assert property (pause_active |-> !reset_pause_select && !quad_pin_config_bit)
		else $error("pause in wrong pin role");
	a_pin_reset_role: assert property (pin_reset |-> reset_pause_select)
		else $error("pin reset in pause role");
	a_cfg_write_gate: assert property ($changed(reset_pause_select) |-> wel_in && !$past(hw_write_protect))
		else $error("config changed while protected");
	c_reset: cover property (mem_reset);
	c_addr: cover property (addr_valid && quad_pin_config_bit);
	c_busy: cover property ($rose(nv_busy));
	c_hwp: cover property (hw_write_protect);
endmodule
bind sfcd_core sfcd_core_props #(.PENW_US(PENW_US)) u_props (
	.clock(clock), .rst_n(rst_n), .cs_n(cs_n), .sio_oe(sio_oe), .wel_in(wel_in),
	.lock_bits_set(lock_bits_set), .cmd_start(cmd_start), .cmd_opcode(cmd_opcode),
	.addr_valid(addr_valid), .mem_reset(mem_reset), .quad_mode(quad_mode),
	.quad_pin_config_bit(quad_pin_config_bit), .reset_pause_select(reset_pause_select),
	.protect_pin_enable_bit(protect_pin_enable_bit),
	.protect_volatility_flag(protect_volatility_flag), .hw_write_protect(hw_write_protect),
	.pause_active(pause_active), .pin_reset(pin_reset), .nv_busy(nv_busy)
);

// *** test/sfcd_host.sv ***
`timescale 1ns/1ns
// Host controller, mode 0; link clock idles low between frames
module sfcd_host (
	input  wire       clock,
	input  wire [3:0] sio_w,
	output reg        sck,
	output reg        cs_n,
	output reg  [3:0] host_d,
	output reg  [3:0] host_oe
);
	reg       lanes4 = 1'b0;
	reg       wp_lvl = 1'b1;
	reg       hold_lvl = 1'b1;
	reg [3:0] lo_n = 4'h4;
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		host_d = 4'hF;
		host_oe = 4'hD;
	end
	// Control pins follow their levels, data line one released
	task pins;
		begin
			@(negedge clock);
			host_oe <= 4'hD;
			host_d <= {hold_lvl, wp_lvl, 2'b11};
		end
	endtask
	task start;
		begin
			@(negedge clock);
			cs_n <= 1'b0;
			repeat (3) @(negedge clock);
		end
	endtask
	// One byte: eight clocks on one lane, two on four lanes
	task xb(input [7:0] tx, input drive, output [7:0] rx);
		integer i;
		begin
			rx = 8'h00;
			for (i = 0; i < (lanes4 ? 2 : 8); i = i + 1) begin
				@(negedge clock);
				sck <= 1'b0;
				if (lanes4) begin
					host_oe <= drive ? 4'hF : 4'h0;
					host_d <= (i == 0) ? tx[7:4] : tx[3:0];
				end else begin
					host_d[0] <= tx[7 - i];
				end
				repeat (lo_n) @(negedge clock);
				rx = lanes4 ? {rx[3:0], sio_w} : {rx[6:0], sio_w[1]};
				sck <= 1'b1;
				repeat (3) @(negedge clock);
			end
		end
	endtask
	task stop;
		begin
			@(negedge clock);
			sck <= 1'b0;
			repeat (4) @(negedge clock);
			cs_n <= 1'b1;
			pins;
			repeat (8) @(negedge clock);
		end
	endtask
endmodule

// *** test/tb_sfcd_core.sv ***
`timescale 1ns/1ns
`include "sfcd_regs.vh"
// Bench for the flash command front end
module tb_sfcd_core;
	reg         clock;
	reg         rst_n = 1'b0;
	reg         wel_in = 1'b0;
	reg         lock_bits_set = 1'b0;
	reg  [7:0]  status_in = 8'h00;
	reg  [7:0]  array_data = 8'h00;
	reg  [15:0] rnd = 16'hDAE8;
	reg  [7:0]  rx;
	reg  [7:0]  v;
	reg  [23:0] addr;
	reg         r;
	integer     bad_count = 0;
	integer     n_compared = 0;
	integer     n_addr = 0;
	integer     n_rst = 0;
	integer     n_for = 0;
	integer     a0;
	integer     k;
	wire        sck, cs_n, array_next, addr_valid, mem_reset, quad_mode, nv_busy, cmd_foreign;
	wire        quad_pin_config_bit, reset_pause_select, protect_pin_enable_bit;
	wire        protect_volatility_flag, hw_write_protect, pause_active, pin_reset;
	wire [3:0]  sio_o, sio_oe, host_d, host_oe, sio_w;
	wire [23:0] cmd_addr;
	// Wire level: host, then device, else pull-up
	assign sio_w = (host_oe & host_d) | (~host_oe & ((sio_oe & sio_o) | ~sio_oe));
	sfcd_host host (.clock(clock), .sio_w(sio_w), .sck(sck), .cs_n(cs_n),
		.host_d(host_d), .host_oe(host_oe));
	sfcd_core #(.PENW_US(2)) dut (.clock(clock), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
		.sio_i(sio_w), .sio_o(sio_o), .sio_oe(sio_oe), .status_in(status_in),
		.wel_in(wel_in), .lock_bits_set(lock_bits_set), .array_data(array_data),
		.array_next(array_next), .cmd_start(), .cmd_opcode(), .cmd_foreign(cmd_foreign),
		.addr_valid(addr_valid), .cmd_addr(cmd_addr), .mem_reset(mem_reset),
		.quad_mode(quad_mode), .quad_pin_config_bit(quad_pin_config_bit),
		.reset_pause_select(reset_pause_select),
		.protect_pin_enable_bit(protect_pin_enable_bit),
		.protect_volatility_flag(protect_volatility_flag),
		.hw_write_protect(hw_write_protect), .pause_active(pause_active),
		.pin_reset(pin_reset), .nv_busy(nv_busy));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// Pulse counters and fresh array bytes
	always @(negedge clock) begin
		n_addr <= n_addr + addr_valid;
		n_rst <= n_rst + mem_reset;
		n_for <= n_for + cmd_foreign;
	end
	always @(negedge clock)
		if (array_next)
			array_data <= rnd[7:0];
	function [7:0] cfg_exp(input qp, input vf, input sel, input pe);
		cfg_exp = {pe, sel, 2'b00, vf, 1'b0, qp, 1'b0};
	endfunction
	task chk(input string name, input logic [23:0] exp, input logic [23:0] got);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("BAD %0s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	task step;
		rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
	endtask
	task op1(input [7:0] op);
		begin
			host.start;
			host.xb(op, 1'b1, rx);
			host.stop;
		end
	endtask
	task wrsr(input [7:0] cfg);
		begin
			host.start;
			host.xb(`SFCD_OP_WRSR, 1'b1, rx);
			host.xb(status_in, 1'b1, rx);
			host.xb(cfg, 1'b1, rx);
			host.stop;
			repeat (25) @(negedge clock);
		end
	endtask
	task rdreg(input [7:0] op);
		begin
			host.start;
			host.xb(op, 1'b1, rx);
			host.xb(8'h00, 1'b0, v);
			host.stop;
		end
	endtask
	// Opcode, address on one or four lanes, one dummy byte
	task rd_addr(input [7:0] op, input q);
		begin
			host.start;
			host.xb(op, 1'b1, rx);
			host.lanes4 = q;
			host.xb(addr[23:16], 1'b1, rx);
			host.xb(addr[15:8], 1'b1, rx);
			host.xb(addr[7:0], 1'b1, rx);
			host.xb(8'h00, 1'b1, rx);
			host.lanes4 = 1'b0;
			host.stop;
		end
	endtask
	task summarize;
		begin
			$display("compared %0d bad %0d", n_compared, bad_count);
			if (bad_count == 0 && n_compared > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		bad_count = bad_count + 1;
		summarize;
	end
	initial begin
		repeat (12) @(negedge clock);
		rst_n = 1'b1;
		status_in = rnd[15:8];
		repeat (4) @(negedge clock);
		chk("qpb", 0, quad_pin_config_bit);
		chk("volf", 1, protect_volatility_flag);
		rdreg(`SFCD_OP_RDCR);
		chk("rdcr", cfg_exp(0, 1, 0, 0), v);
		rdreg(`SFCD_OP_RDSR);
		chk("status", status_in, v);
		step;
		addr = {rnd, rnd[11:4]};
		a0 = n_addr;
		k = n_for;
		rd_addr(`SFCD_OP_QOR, 1'b0);
		op1(`SFCD_OP_QPP);
		chk("refused", a0, n_addr);
		chk("qpp_refused", k, n_for);
		$display("power-up and refusal done");
		r = rnd[0];
		wel_in = 1'b1;
		host.start;
		host.xb(`SFCD_OP_WRSR, 1'b1, rx);
		host.xb(status_in, 1'b1, rx);
		host.xb(cfg_exp(0, 0, r, 1), 1'b1, rx);
		host.stop;
		chk("busy", 1, nv_busy);
		repeat (25) @(negedge clock);
		chk("busy_end", 0, nv_busy);
		chk("sel", r, reset_pause_select);
		chk("volf_ro", 1, protect_volatility_flag);
		host.wp_lvl = 1'b0;
		host.pins;
		repeat (5) @(negedge clock);
		chk("hwp_on", 1, hw_write_protect);
		wrsr(cfg_exp(1, 0, r, 1));
		chk("qpb_locked", 0, quad_pin_config_bit);
		host.wp_lvl = 1'b1;
		host.pins;
		repeat (5) @(negedge clock);
		chk("hwp_off", 0, hw_write_protect);
		host.hold_lvl = 1'b0;
		host.pins;
		repeat (5) @(negedge clock);
		chk("pause", !r, pause_active);
		chk("pin_rst", r, pin_reset);
		host.hold_lvl = 1'b1;
		host.pins;
		$display("protection and pins done");
		wrsr(cfg_exp(1, 0, r, 0));
		chk("qpb_set", 1, quad_pin_config_bit);
		host.lo_n = 4'hA;
		rdreg(`SFCD_OP_RDCR);
		host.lo_n = 4'h4;
		chk("rdcr_qpb", cfg_exp(1, 1, r, 0), v);
		// Quad output, quad I/O, then double-rate quad output read
		for (k = 0; k < 3; k = k + 1) begin
			step;
			addr = {rnd, rnd[12:5]};
			a0 = n_addr;
			rd_addr(k == 2 ? `SFCD_OP_QORDTR : k ? `SFCD_OP_QIOR : `SFCD_OP_QOR, k == 1);
			chk("addr_seen", a0 + 1, n_addr);
			if (k < 2)
				chk("addr", addr, cmd_addr);
		end
		k = n_for;
		op1(`SFCD_OP_QPP);
		chk("qpp_foreign", k + 1, n_for);
		$display("quad reads done");
		a0 = n_rst;
		op1(`SFCD_OP_ARM);
		op1(`SFCD_OP_RST);
		chk("reset", a0 + 1, n_rst);
		op1(`SFCD_OP_ARM);
		op1(`SFCD_OP_NOP);
		op1(`SFCD_OP_RST);
		chk("disarmed", a0 + 1, n_rst);
		op1(`SFCD_OP_EQIO);
		chk("quad_on", 1, quad_mode);
		host.lanes4 = 1'b1;
		op1(`SFCD_OP_ARM);
		op1(`SFCD_OP_RST);
		host.lanes4 = 1'b0;
		chk("reset_x4", a0 + 2, n_rst);
		chk("quad_off", 0, quad_mode);
		lock_bits_set = 1'b1;
		repeat (3) @(negedge clock);
		chk("locked", 0, protect_volatility_flag);
		$display("reset and lock done");
		summarize;
	end
endmodule
